// ==== tprs_defines.vh ====
// constants for the tributary pattern and receive setup block
// What this block does
// - prbs 23/20/15 and qrss 20 sources
// - one-in-eight sends word 01000000
// - three-in-24 sends 01000100 00000000 00000100
// - user word 8/16/24 bits, reports user-defined
// - user word preset zeros, ones, 10101010, arbitrary
// - transmit and receive settings kept separate
// - auto scan loads receive from detected signal
// - receive rates sts1 sts3 oc1 oc3 oc12
// - receive rates ds1 ds3 ds3-to-ds1
// - reject receive ds1 with transmit ds3 on config writes, auto scan not checked
// - tributary mappings equal or bulk fill on config writes, auto scan not checked
// - coupled changes copy to other side
// - coupling overwrites the non-originating side
// - independent mode ends coupling, status shows it
// - relock on rate reselect or los
// - receive level cross_connect_level low high monitor
// - structure sts-1 or sts-3c for high rates
`ifndef TPRS_DEFINES_VH
`define TPRS_DEFINES_VH
// apb register byte offsets
`define TPRS_TX_CFG      12'h000
`define TPRS_RX_CFG      12'h004
`define TPRS_USER_WORD   12'h008
`define TPRS_CMD         12'h00c
`define TPRS_STATUS      12'h010
// config fields: rate[3:0] pattern[7:4] map[10:8] level[12:11] struct[13]
`define TPRS_RATE_LO     0
`define TPRS_RATE_HI     3
`define TPRS_PAT_LO      4
`define TPRS_PAT_HI      7
`define TPRS_MAP_LO      8
`define TPRS_MAP_HI      10
`define TPRS_LVL_LO      11
`define TPRS_LVL_HI      12
`define TPRS_STRUCT_BIT  13
`define TPRS_CFG_W       14
// rates
`define TPRS_R_STS1      4'h0
`define TPRS_R_STS3      4'h1
`define TPRS_R_OC1       4'h2
`define TPRS_R_OC3       4'h3
`define TPRS_R_OC12      4'h4
`define TPRS_R_DS1       4'h5
`define TPRS_R_DS3       4'h6
`define TPRS_R_DS3DS1    4'h7
// patterns
`define TPRS_P_PRBS23    4'h0
`define TPRS_P_PRBS20    4'h1
`define TPRS_P_PRBS15    4'h2
`define TPRS_P_QRSS      4'h3
`define TPRS_P_ONE8      4'h4
`define TPRS_P_ONES      4'h5
`define TPRS_P_ZEROS     4'h6
`define TPRS_P_USER8     4'h7
`define TPRS_P_USER16    4'h8
`define TPRS_P_USER24    4'h9
`define TPRS_P_THREE24   4'ha
// mappings
`define TPRS_M_BULK_EQ   3'h0
`define TPRS_M_BULK_UNEQ 3'h1
`define TPRS_M_DS3       3'h2
`define TPRS_M_VT15      3'h3
`define TPRS_M_DS3DS1    3'h4
// fixed words
`define TPRS_ONE8_WORD   8'h40
`define TPRS_THREE24_WORD 24'h440004
`define TPRS_USER_DEF    24'haaaaaa
`define TPRS_USER_ONES   24'hffffff
`define TPRS_USER_ZEROS  24'h000000
// command bits
`define TPRS_C_SCAN      0
`define TPRS_C_COUPLE_RX 1
`define TPRS_C_COUPLE_TX 2
`define TPRS_C_INDEP     3
`define TPRS_C_USER_ZERO 4
`define TPRS_C_USER_ONE  5
`define TPRS_C_USER_DEF  6
`define TPRS_C_RESELECT  7
// prbs taps (bit index of feedback pair)
`define TPRS_TAP23_A     22
`define TPRS_TAP23_B     17
`define TPRS_TAP20_A     19
`define TPRS_TAP20_B     16
`define TPRS_TAP15_A     14
`define TPRS_TAP15_B     13
`define TPRS_QRSS_RUN    14
`define TPRS_CFG_RST     14'h0000
`endif

// ==== tprs_line_model.sv ====
// far-end line model: new incoming signal preceded by a loss interval
module tprs_line_model #(parameter int LOS_CYC = 6) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         change,
    input  wire  [13:0] new_cfg,
    output logic        rx_los,
    output logic [13:0] detected_cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt; // loss cycles still to present
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            rx_los <= 1'b0;
            detected_cfg <= 14'h0000;
        end else if (change) begin
            cnt <= LOS_CYC;
            rx_los <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
            // no signal: what is seen is junk, so keep it moving
            detected_cfg <= ~detected_cfg;
        end else if (cnt == 1) begin
            cnt <= 0;
            rx_los <= 1'b0;
            detected_cfg <= new_cfg;
        end
    end
endmodule

// ==== tprs_pattern_gen.v ====
// pattern bit generator, registered output
`include "tprs_defines.vh"
module tprs_pattern_gen (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        bit_en,
    input  wire [3:0]  pattern,
    input  wire [23:0] user_word,
    output reg         tx_bit
);
    reg  [22:0] lfsr_reg;   // shared prbs shift register
    reg  [4:0]  pos_reg;    // bit position in word
    reg  [4:0]  zrun_reg;   // qrss zero run counter
    reg  [4:0]  wlen;       // word length of fixed pattern
    reg  [23:0] word;       // fixed pattern, msb aligned
    reg         fb;         // lfsr feedback
    reg         pbit;       // chosen next bit
    reg         stuck;      // active lfsr span all zero
    // word select and feedback per pattern
    always @* begin
        wlen = 5'd24;
        word = 24'h000000;
        fb   = lfsr_reg[`TPRS_TAP23_A] ^ lfsr_reg[`TPRS_TAP23_B];
        // shorter sequences only see the low bits, so lock-up is judged there
        stuck = (lfsr_reg == 23'h000000);
        case (pattern)
            `TPRS_P_ONE8: begin
                wlen = 5'd8;
                word = {`TPRS_ONE8_WORD, 16'h0000};
            end
            `TPRS_P_THREE24: word = `TPRS_THREE24_WORD;
            `TPRS_P_ONES: word = 24'hffffff;
            `TPRS_P_USER8: begin
                wlen = 5'd8;
                word = {user_word[7:0], 16'h0000};
            end
            `TPRS_P_USER16: begin
                wlen = 5'd16;
                word = {user_word[15:0], 8'h00};
            end
            `TPRS_P_USER24: word = user_word;
            `TPRS_P_PRBS20: begin
                fb    = lfsr_reg[`TPRS_TAP20_A] ^ lfsr_reg[`TPRS_TAP20_B];
                stuck = (lfsr_reg[19:0] == 20'h00000);
            end
            `TPRS_P_QRSS: begin
                fb    = lfsr_reg[`TPRS_TAP20_A] ^ lfsr_reg[`TPRS_TAP20_B];
                stuck = (lfsr_reg[19:0] == 20'h00000);
            end
            `TPRS_P_PRBS15: begin
                fb    = lfsr_reg[`TPRS_TAP15_A] ^ lfsr_reg[`TPRS_TAP15_B];
                stuck = (lfsr_reg[14:0] == 15'h0000);
            end
            default: wlen = 5'd24;
        endcase
        pbit = word[5'd23 - pos_reg];
        if (pattern <= `TPRS_P_QRSS)
            pbit = fb;
        // qrss forces a one after a long zero run, limiting zero density
        if (pattern == `TPRS_P_QRSS && zrun_reg >= `TPRS_QRSS_RUN)
            pbit = 1'b1;
    end
    // shift one bit per enabled slot, no gaps between repeats
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_reg <= 23'h7fffff;
            pos_reg  <= 5'd0;
            zrun_reg <= 5'd0;
            tx_bit   <= 1'b0;
        end else if (clk_en && bit_en) begin
            lfsr_reg <= {lfsr_reg[21:0], fb};
            // lock-up guard: all-zero active span would never leave
            if (stuck)
                lfsr_reg <= 23'h7fffff;
            if (pos_reg >= wlen - 5'd1)
                pos_reg <= 5'd0;
            else
                pos_reg <= pos_reg + 5'd1;
            zrun_reg <= pbit ? 5'd0 : zrun_reg + 5'd1;
            tx_bit   <= pbit;
        end
    end
endmodule

// ==== tprs_setup.v ====
// tributary pattern source and receive settings over apb
//
// Local design decisions: the register offsets and the APB register port.
`include "tprs_defines.vh"
module tprs_setup (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        bit_en,
    input  wire        rx_los,
    input  wire [13:0] detected_cfg,
    output wire        tx_bit,
    output reg         rx_relock,
    output wire [13:0] rx_cfg_out,
    output wire [13:0] tx_cfg_out,
    output wire        coupled,
    output wire        user_defined
);
    reg  [13:0] tx_cfg_reg;      // transmit parameter set
    reg  [13:0] rx_cfg_reg;      // receive parameter set
    reg  [23:0] user_word_reg;   // programmable user word
    reg         coupled_reg;     // settings linked
    reg         reject_reg;      // last config write refused, cleared by the next legal one
    reg  [31:0] prdata_reg;      // registered read data
    reg         los_d_reg;       // los edge detect
    reg  [13:0] tx_cand;         // candidate transmit set
    reg  [13:0] rx_cand;         // candidate receive set
    reg         legal;           // candidate passes checks
    reg         wr_tx;           // transmit set written
    reg         wr_rx;           // receive set written
    wire        access;          // apb access phase
    wire        wr;              // write strobe
    wire [7:0]  cmd;             // command bits
    // decode functions used more than once
    function is_trib;
        input [3:0] r;
        begin
            is_trib = (r == `TPRS_R_DS1) || (r == `TPRS_R_DS3) || (r == `TPRS_R_DS3DS1);
        end
    endfunction
    function is_bulk;
        input [2:0] m;
        begin
            is_bulk = (m == `TPRS_M_BULK_EQ) || (m == `TPRS_M_BULK_UNEQ);
        end
    endfunction
    function rate_ok;
        input [3:0] r;
        begin
            rate_ok = (r <= `TPRS_R_DS3DS1);
        end
    endfunction
    // single cycle apb slave, no wait states
    assign access  = psel & penable;
    assign wr      = access & pwrite & clk_en;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign cmd     = pwdata[7:0];
    assign prdata  = prdata_reg;
    // candidate settings and legality checks
    always @* begin
        tx_cand = tx_cfg_reg;
        rx_cand = rx_cfg_reg;
        wr_tx   = wr && paddr == `TPRS_TX_CFG;
        wr_rx   = wr && paddr == `TPRS_RX_CFG;
        // each write touches its own set, and the other set as well when coupled
        if (wr_tx)
            tx_cand = pwdata[13:0];
        if (wr_rx)
            rx_cand = pwdata[13:0];
        if (coupled_reg && wr_tx)
            rx_cand = pwdata[13:0];
        if (coupled_reg && wr_rx)
            tx_cand = pwdata[13:0];
        legal = rate_ok(rx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO])
              && rate_ok(tx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO])
              && tx_cand[`TPRS_PAT_HI:`TPRS_PAT_LO] <= `TPRS_P_THREE24;
        // no receive ds1 with transmit ds3
        if (rx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO] == `TPRS_R_DS1
            && tx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO] == `TPRS_R_DS3)
            legal = 1'b0;
        // tributary mappings must match or be bulk
        if ((is_trib(rx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO]) || is_trib(tx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO]))
            && rx_cand[`TPRS_MAP_HI:`TPRS_MAP_LO] != tx_cand[`TPRS_MAP_HI:`TPRS_MAP_LO]
            && !is_bulk(rx_cand[`TPRS_MAP_HI:`TPRS_MAP_LO])
            && !is_bulk(tx_cand[`TPRS_MAP_HI:`TPRS_MAP_LO]))
            legal = 1'b0;
        // qrss only at ds1 transmit rate
        if (tx_cand[`TPRS_PAT_HI:`TPRS_PAT_LO] == `TPRS_P_QRSS
            && tx_cand[`TPRS_RATE_HI:`TPRS_RATE_LO] != `TPRS_R_DS1)
            legal = 1'b0;
    end
    // settings registers and commands
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cfg_reg    <= `TPRS_CFG_RST;
            rx_cfg_reg    <= `TPRS_CFG_RST;
            user_word_reg <= `TPRS_USER_DEF;
            coupled_reg   <= 1'b0;
            reject_reg    <= 1'b0;
        end else if (clk_en) begin
            // config write, refused whole if illegal
            if (wr_tx || wr_rx) begin
                if (legal) begin
                    tx_cfg_reg <= tx_cand;
                    rx_cfg_reg <= rx_cand;
                end
                reject_reg <= !legal;
            end
            if (wr && paddr == `TPRS_USER_WORD)
                user_word_reg <= pwdata[23:0];
            if (wr && paddr == `TPRS_CMD) begin
                if (cmd[`TPRS_C_USER_ZERO])
                    user_word_reg <= `TPRS_USER_ZEROS;
                else if (cmd[`TPRS_C_USER_ONE])
                    user_word_reg <= `TPRS_USER_ONES;
                else if (cmd[`TPRS_C_USER_DEF])
                    user_word_reg <= `TPRS_USER_DEF;
                if (cmd[`TPRS_C_SCAN]) begin
                    rx_cfg_reg <= detected_cfg;
                    if (coupled_reg)
                        tx_cfg_reg <= detected_cfg;
                end
                if (cmd[`TPRS_C_COUPLE_RX]) begin
                    tx_cfg_reg  <= rx_cfg_reg;
                    coupled_reg <= 1'b1;
                end else if (cmd[`TPRS_C_COUPLE_TX]) begin
                    rx_cfg_reg  <= tx_cfg_reg;
                    coupled_reg <= 1'b1;
                end
                if (cmd[`TPRS_C_INDEP])
                    coupled_reg <= 1'b0;
            end
        end
    end
    // relock pulse on reselect or los falling edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_d_reg <= 1'b0;
            rx_relock <= 1'b0;
        end else if (clk_en) begin
            los_d_reg <= rx_los;
            // relock after reselect or valid los
            rx_relock <= (los_d_reg && !rx_los)
                       || (wr_rx && legal)
                       || (wr && paddr == `TPRS_CMD && cmd[`TPRS_C_RESELECT]);
        end
    end
    // read data registered in setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_reg <= 32'h00000000;
        else if (clk_en && psel && !penable) begin
            case (paddr)
                `TPRS_TX_CFG:    prdata_reg <= {18'h00000, tx_cfg_reg};
                `TPRS_RX_CFG:    prdata_reg <= {18'h00000, rx_cfg_reg};
                `TPRS_USER_WORD: prdata_reg <= {8'h00, user_word_reg};
                `TPRS_STATUS:    prdata_reg <= {29'h00000000, user_defined, reject_reg, coupled_reg};
                default:         prdata_reg <= 32'h00000000;
            endcase
        end
    end
    // level and structure go out with rx set
    assign rx_cfg_out = rx_cfg_reg;
    assign tx_cfg_out = tx_cfg_reg;
    assign coupled    = coupled_reg;
    assign user_defined = tx_cfg_reg[`TPRS_PAT_HI:`TPRS_PAT_LO] >= `TPRS_P_USER8
                       && tx_cfg_reg[`TPRS_PAT_HI:`TPRS_PAT_LO] <= `TPRS_P_USER24;
    // transmit pattern generator
    tprs_pattern_gen u_gen (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .bit_en    (bit_en),
        .pattern   (tx_cfg_reg[`TPRS_PAT_HI:`TPRS_PAT_LO]),
        .user_word (user_word_reg),
        .tx_bit    (tx_bit)
    );
endmodule

// ==== tprs_setup_sva.sv ====
// assertion checker for the pattern and receive setup block
`include "tprs_defines.vh"
module tprs_setup_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        rx_relock,
    input wire [13:0] rx_cfg_out,
    input wire [13:0] tx_cfg_out,
    input wire        coupled,
    input wire        user_defined
);
    timeunit 1ns;
    timeprecision 1ns;
    // access edge and decoded config fields
    wire       wr_acc = psel && penable && pwrite && clk_en;
    wire [3:0] rr     = rx_cfg_out[3:0];
    wire [3:0] tr     = tx_cfg_out[3:0];
    wire [3:0] tp     = tx_cfg_out[7:4];
    wire [2:0] rm     = rx_cfg_out[10:8];
    wire [2:0] tm     = tx_cfg_out[10:8];
    // either side at a tributary rate makes mapping matter
    wire       trib   = rr >= `TPRS_R_DS1 || tr >= `TPRS_R_DS1;
    wire       bulk   = rm <= `TPRS_M_BULK_UNEQ || tm <= `TPRS_M_BULK_UNEQ;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_user_flag: assert property (user_defined == (tp >= `TPRS_P_USER8 && tp <= `TPRS_P_USER24))
        else $error("user flag does not follow pattern");
    a_relock_pulse: assert property (rx_relock |=> !rx_relock)
        else $error("relock longer than one cycle");
    a_coupled_equal: assert property (coupled |-> rx_cfg_out == tx_cfg_out)
        else $error("coupled sets differ");
    a_no_ds1_ds3: assert property (!(rr == `TPRS_R_DS1 && tr == `TPRS_R_DS3))
        else $error("receive ds1 with transmit ds3");
    a_map_legal: assert property (trib |-> tm == rm || bulk)
        else $error("tributary mappings clash");
    a_qrss_ds1: assert property (tp == `TPRS_P_QRSS |-> tr == `TPRS_R_DS1)
        else $error("qrss away from ds1");
    a_indep_ends: assert property (wr_acc && paddr == `TPRS_CMD && pwdata[`TPRS_C_INDEP] |=> !coupled)
        else $error("coupling survived independent");
    a_cfg_hold: assert property (!wr_acc |=> $stable(tx_cfg_out) && $stable(rx_cfg_out))
        else $error("config moved without a write");
endmodule

// ==== tprs_setup_test.sv ====
// self-checking bench for the pattern and receive setup block
`include "tprs_defines.vh"
module tprs_setup_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] TXC = `TPRS_TX_CFG, RXC = `TPRS_RX_CFG, UWA = `TPRS_USER_WORD;
    localparam logic [11:0] CMD = `TPRS_CMD, STA = `TPRS_STATUS;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, bit_en, chg;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [13:0] ncfg;     // next signal from the far end
    logic [15:0] lf;       // random source state
    logic [23:0] uw;       // user word written
    logic [47:0] win;      // recent transmit bits
    logic [31:0] expq[$];  // expected read data, oldest first
    int          error_cnt, checks_done, relocks, n;
    wire  [31:0] prdata;
    wire         pready, pslverr, tx_bit, rx_relock, coupled, user_defined, rx_los;
    wire  [13:0] rx_cfg_out, tx_cfg_out, detected_cfg;
    tprs_setup tprs_setup_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_en(bit_en), .rx_los(rx_los), .detected_cfg(detected_cfg), .tx_bit(tx_bit), .rx_relock(rx_relock),
        .rx_cfg_out(rx_cfg_out), .tx_cfg_out(tx_cfg_out), .coupled(coupled), .user_defined(user_defined));
    tprs_line_model tprs_line_model_i (.pclk(pclk), .presetn(presetn), .change(chg), .new_cfg(ncfg),
        .rx_los(rx_los), .detected_cfg(detected_cfg));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // true if s is some rotation of the periodic word e
    function automatic logic rotm(input logic [47:0] s, input logic [47:0] e);
        logic [95:0] t;
        for (int k = 0; k < 48; k++) begin
            t = {e, e} >> k;
            if (t[47:0] === s) return 1'b1;
        end
        return 1'b0;
    endfunction
    // true if every bit is the xor of the two tap-delayed bits, and not stuck
    function automatic logic prbs_ok(input logic [47:0] s, input int a, input int b);
        for (int i = 0; i + a < 48; i++)
            if (s[i] !== (s[i + a] ^ s[i + b]))
                return 1'b0;
        return s != 48'h0;
    endfunction
    // true if no run of fifteen zeros and not stuck
    function automatic logic runs_ok(input logic [47:0] s);
        for (int i = 0; i < 34; i++)
            if (s[i +: 15] === 15'h0000)
                return 1'b0;
        return s != 48'h0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // one apb transfer; an idle edge follows so psel is never set twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40) begin
            error_cnt++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // send a pattern at ds1 and look at 48 transmitted bits
    task automatic grab(input logic [3:0] p);
        wr(TXC, {24'h0, p, `TPRS_R_DS1});
        cyc(4);
        repeat (48) begin
            @(posedge pclk);
            win = {win[46:0], tx_bit};
        end
    endtask
    task automatic pcheck(input logic [3:0] p, input logic [47:0] e, input logic ud);
        grab(p);
        check(rotm(win, e), 1);
        check(user_defined, ud);
    endtask
    // completed reads are matched to the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check(prdata, expq.pop_front());
        if (psel && penable && pready)
            check(pslverr, 1'b0);
        if (rx_relock === 1'b1)
            relocks++;
    end
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, clk_en, psel, penable, pwrite, chg, bit_en} = 7'b0100001;
        paddr = 12'h000;
        pwdata = 32'h0;
        ncfg = 14'h0923;
        lf = 16'h0033;
        {error_cnt, checks_done, relocks} = 0;
        cyc(4);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TXC, 32'h0);
        rd(UWA, 32'h00aaaaaa);
        rd(STA, 32'h0);
        rd(12'h020, 32'h0);
        wr(CMD, 32'h10);
        rd(UWA, 32'h0);
        wr(CMD, 32'h20);
        rd(UWA, 32'h00ffffff);
        wr(CMD, 32'h40);
        rd(UWA, 32'h00aaaaaa);
        lf = lfsr(lf);
        uw[23:8] = lf;
        lf = lfsr(lf);
        uw[7:0] = lf[7:0];
        wr(UWA, {8'h0, uw});
        rd(UWA, {8'h0, uw});
        grab(`TPRS_P_PRBS23);
        check(prbs_ok(win, `TPRS_TAP23_A + 1, `TPRS_TAP23_B + 1), 1);
        grab(`TPRS_P_PRBS20);
        check(prbs_ok(win, `TPRS_TAP20_A + 1, `TPRS_TAP20_B + 1), 1);
        grab(`TPRS_P_PRBS15);
        check(prbs_ok(win, `TPRS_TAP15_A + 1, `TPRS_TAP15_B + 1), 1);
        grab(`TPRS_P_QRSS);
        check(runs_ok(win), 1);
        pcheck(`TPRS_P_ONE8, {6{8'h40}}, 1'b0);
        pcheck(`TPRS_P_THREE24, {2{24'h440004}}, 1'b0);
        pcheck(`TPRS_P_ONES, {48{1'b1}}, 1'b0);
        pcheck(`TPRS_P_ZEROS, 48'h0, 1'b0);
        pcheck(`TPRS_P_USER8, {6{uw[7:0]}}, 1'b1);
        pcheck(`TPRS_P_USER16, {3{uw[15:0]}}, 1'b1);
        pcheck(`TPRS_P_USER24, {2{uw}}, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(RXC, {18'h0, i[2], i[1:0], 7'h0, i[3:0]});
            check({18'h0, rx_cfg_out}, {18'h0, i[2], i[1:0], 7'h0, i[3:0]});
        end
        wr(TXC, 32'h6);
        wr(RXC, 32'h5);
        check(rx_cfg_out, 32'h3807);
        rd(STA, 32'h2);
        wr(TXC, 32'h0206);
        wr(RXC, 32'h0304);
        check(rx_cfg_out, 32'h3807);
        wr(RXC, 32'h0104);
        check(rx_cfg_out, 32'h0104);
        wr(TXC, 32'h0036);
        check(tx_cfg_out, 32'h0206);
        wr(TXC, 32'h0035);
        check(tx_cfg_out, 32'h0035);
        cyc(3);
        n = relocks;
        chg <= 1'b1;
        @(posedge pclk);
        chg <= 1'b0;
        cyc(12);
        check(relocks - n, 1);
        n = relocks;
        wr(CMD, 32'h80);
        cyc(3);
        check(relocks - n, 1);
        wr(CMD, 32'h01);
        check(rx_cfg_out, 32'h0923);
        wr(CMD, 32'h02);
        check(tx_cfg_out, 32'h0923);
        check(coupled, 1);
        wr(TXC, 32'h0140);
        check(rx_cfg_out, 32'h0140);
        wr(CMD, 32'h08);
        rd(STA, 32'h0);
        wr(TXC, 32'h0000);
        check(rx_cfg_out, 32'h0140);
        wr(CMD, 32'h04);
        check(rx_cfg_out, 32'h0000);
        clk_en <= 1'b0;
        wr(RXC, 32'h0001);
        clk_en <= 1'b1;
        check(rx_cfg_out, 32'h0000);
        // mid-run reset brings back the preset state
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        @(posedge pclk);
        check(coupled, 1'b0);
        rd(UWA, 32'h00aaaaaa);
        results();
    end
endmodule
bind tprs_setup tprs_setup_sva tprs_setup_sva_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_relock(rx_relock),
    .rx_cfg_out(rx_cfg_out), .tx_cfg_out(tx_cfg_out), .coupled(coupled), .user_defined(user_defined));
